// ### clock_select_assertions.sv
// Port-level assertions for the system clock selection block
`default_nettype none
module clock_select_checker
  import clock_select_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WE,
  input wire logic       SFR_RE,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       EXT_OSC_IN,
  input wire logic [3:0] PORT_MATCH,
  input wire logic       CMP0_ENABLE,
  input wire logic       CMP0_OUT,
  input wire logic       SYSTEM_CLOCK_EN,
  input wire logic       EXT_CLK_EN,
  input wire src_t       CLK_SOURCE,
  input wire logic       SYSTEM_CLOCK_STOPPED
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_boot_internal: assert property (
    !$past(RST_N) |-> CLK_SOURCE == SRC_INT)
    else $error("source not internal after reset");
  a_no_reserved: assert property (
    CLK_SOURCE != SRC_RSVD)
    else $error("reserved source driving clock");
  a_select_upper: assert property (
    SFR_RE && SFR_ADDR == ADDR_CLK_SEL
    |=> SFR_RDATA[7:2] == 6'h00 && SFR_RDATA[1:0] != 2'h3)
    else $error("select register read bad");
  a_ready_flag: assert property (
    SFR_RE && SFR_ADDR == ADDR_INT_OSC |=> !SFR_RDATA[3] &&
    SFR_RDATA[4] == (SFR_RDATA[7:6] == OSC_ON && !SFR_RDATA[5]))
    else $error("frequency ready flag wrong");
  a_stop_quiet: assert property (
    SYSTEM_CLOCK_STOPPED [*3] |-> !SYSTEM_CLOCK_EN)
    else $error("clock pulse while suspended");
  a_port_wake: assert property (
    SYSTEM_CLOCK_STOPPED && |PORT_MATCH && !SFR_WE
    |-> ##[1:3] !SYSTEM_CLOCK_STOPPED)
    else $error("port match did not wake");
  a_cmp_wake: assert property (
    SYSTEM_CLOCK_STOPPED && CMP0_ENABLE && !CMP0_OUT && !SFR_WE
    |-> ##[1:3] !SYSTEM_CLOCK_STOPPED)
    else $error("comparator did not wake");
  a_ext_edge: assert property (
    EXT_CLK_EN |-> $past(EXT_OSC_IN) && !$past(EXT_OSC_IN, 2))
    else $error("external pulse without edge");
endmodule
bind system_clock_selection clock_select_checker chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
  .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_WDATA(SFR_WDATA),
  .SFR_RDATA(SFR_RDATA), .EXT_OSC_IN(EXT_OSC_IN),
  .PORT_MATCH(PORT_MATCH), .CMP0_ENABLE(CMP0_ENABLE),
  .CMP0_OUT(CMP0_OUT), .SYSTEM_CLOCK_EN(SYSTEM_CLOCK_EN), .EXT_CLK_EN(EXT_CLK_EN),
  .CLK_SOURCE(CLK_SOURCE), .SYSTEM_CLOCK_STOPPED(SYSTEM_CLOCK_STOPPED));
`default_nettype wire

// ### clock_select_pkg.sv
// Constants and types for the system clock selection block
//
// What this block does
// - Source code picks internal, external or multiplier
// - Select register resets zero, upper bits read zero
// - External oscillator still clocks timers and counters
// - Internal oscillator usable right after enable write
// - Hardware sets crystal valid once crystal settles
// - Internal oscillator is system clock after reset
// - Internal clock divided 1 to 128, resets 128
// - Trim settings reset to 24 MHz values
// - Multiplier base: internal x2, external x2, x4
// - Multiplier base scaled by 1 or 2/3..2/7
// - Suspend bit halts internal oscillator and the clocks taken from it
// - Port match or comparator low ends suspend
// - Wake event resumes operation regardless of interrupts
// - Processor continues after the suspend write
// - Coarse and fine trims adjust oscillator period
// - Divider code 000 is /128, 111 is /1
// - Enable field 00 off, 11 on, others reserved
// - Frequency ready reads 1 when oscillator runs
`default_nettype none
package clock_select_pkg;
  // --------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK_SEL = 8'h8f;
  localparam logic [7:0] ADDR_INT_OSC = 8'ha1;
  localparam logic [7:0] ADDR_COARSE  = 8'ha2;
  localparam logic [7:0] ADDR_FINE    = 8'h9e;
  localparam logic [7:0] ADDR_EXT_OSC = 8'h9f;
  localparam logic [7:0] ADDR_MULT    = 8'h97;
  // --------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------
  localparam int INT_EN_LSB      = 6;
  localparam int SUSPEND_BIT     = 5;
  localparam int EXT_MODE_LSB    = 4;
  localparam int MULT_SCALE_LSB  = 2;
  localparam int MULT_ENABLE_BIT = 7;
  localparam logic [1:0] RST_INT_EN   = 2'h3;
  localparam logic [2:0] RST_DIV_CODE = 3'h0;
  localparam logic [6:0] RST_COARSE   = 7'h4c;
  localparam logic [5:0] RST_FINE     = 6'h33;
  localparam logic [2:0] RST_EXT_MODE = 3'h0;
  localparam logic [1:0] OSC_OFF      = 2'h0;
  localparam logic [1:0] OSC_ON       = 2'h3;
  localparam logic [2:0] EXT_OFF      = 3'h0;
  localparam logic [2:0] EXT_XTAL     = 3'h6;
  localparam logic [2:0] SCALE_MIN    = 3'h2;
  // Crystal edges counted before it is declared settled
  localparam logic [10:0] XTAL_SETTLE_EDGES = 11'h400;
  // --------------------------------------------------------------
  // Enumerations
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_INT  = 2'b00,
    SRC_EXT  = 2'b01,
    SRC_MULT = 2'b10,
    SRC_RSVD = 2'b11
  } src_t;
  typedef enum logic [1:0] {
    MB_INT_X2 = 2'b00,
    MB_EXT_X2 = 2'b01,
    MB_EXT_X4 = 2'b10
  } mult_base_t;
  typedef enum logic [1:0] {
    SW_RUN   = 2'b00,
    SW_DRAIN = 2'b01,
    SW_ARM   = 2'b10
  } switch_t;
endpackage
`default_nettype wire

// ### ext_osc_model.sv
// Behavioural model of the external crystal feeding the block
`default_nettype none
module ext_osc_model #(
  parameter int HALF = 3
) (
  input  wire logic clk,
  output logic      osc
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt   = 0;
  logic level = 1'b0;
  assign osc = level;
  // A crystal runs free once powered; changes just after the edge
  always @(posedge clk) begin
    #1;
    cnt = (cnt + 1) % HALF;
    if (cnt == 0)
      level = !level;
  end
endmodule
`default_nettype wire

// ### system_clock_selection.sv
// System clock source selection, internal oscillator and multiplier
`default_nettype none
module system_clock_selection (
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST_N,
  input  wire logic [7:0]              SFR_ADDR,
  input  wire logic                    SFR_WE,
  input  wire logic                    SFR_RE,
  input  wire logic [7:0]              SFR_WDATA,
  output logic      [7:0]              SFR_RDATA,
  input  wire logic                    EXT_OSC_IN,
  input  wire logic [3:0]              PORT_MATCH,
  input  wire logic                    CMP0_ENABLE,
  input  wire logic                    CMP0_OUT,
  output logic                         SYSTEM_CLOCK_EN,
  output logic                         EXT_CLK_EN,
  output clock_select_pkg::src_t       CLK_SOURCE,
  output logic                         SYSTEM_CLOCK_STOPPED
);
  import clock_select_pkg::*;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'(7'h7f >> code);
  endfunction

  function automatic logic field_addr_hit(
    input logic [7:0] addr, input logic [7:0] target);
    field_addr_hit = addr == target;
  endfunction

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  src_t        clk_sel;
  logic [1:0]  int_en;
  logic        suspend;
  logic [2:0]  div_code;
  logic [6:0]  coarse;
  logic [5:0]  fine;
  logic [12:0] osc_acc;
  logic [6:0]  div_cnt;
  logic [2:0]  ext_mode;
  logic        ext_prev;
  logic [10:0] settle_cnt;
  logic        xtal_valid;
  logic        mult_en;
  mult_base_t  mult_base;
  logic [2:0]  mult_scale;
  logic [2:0]  credits;
  logic [3:0]  scale_acc;
  src_t        cur_src;
  switch_t     sw_state;

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  wire wr_sel    = SFR_WE && field_addr_hit(SFR_ADDR, ADDR_CLK_SEL);
  wire wr_int    = SFR_WE && field_addr_hit(SFR_ADDR, ADDR_INT_OSC);
  wire wr_coarse = SFR_WE && field_addr_hit(SFR_ADDR, ADDR_COARSE);
  wire wr_fine   = SFR_WE && field_addr_hit(SFR_ADDR, ADDR_FINE);
  wire wr_ext    = SFR_WE && field_addr_hit(SFR_ADDR, ADDR_EXT_OSC);
  wire wr_mult   = SFR_WE && field_addr_hit(SFR_ADDR, ADDR_MULT);
  wire [1:0] wr_src  = SFR_WDATA[1:0];
  wire       sel_ok  = wr_src != SRC_RSVD;

  // --------------------------------------------------------------
  // Internal oscillator
  // --------------------------------------------------------------
  wire wake = (|PORT_MATCH) || (CMP0_ENABLE && !CMP0_OUT);
  wire next_suspend = wr_int ? SFR_WDATA[SUSPEND_BIT]
                    : (wake ? 1'b0 : suspend);
  // Runs the very cycle after the enabling write
  wire osc_run = (int_en == OSC_ON) && !suspend;
  // Phase step from both trims; 4915/8192 of 40 MHz is 24 MHz
  wire [13:0] osc_sum = {1'b0, osc_acc} + {1'b0, coarse, fine};
  wire int_tick = osc_run && osc_sum[13];
  wire [6:0] mask = div_mask(div_code);
  wire div_tick = int_tick && ((div_cnt & mask) == mask);

  // --------------------------------------------------------------
  // External oscillator
  // --------------------------------------------------------------
  wire ext_tick = EXT_OSC_IN && !ext_prev && (ext_mode != EXT_OFF);
  wire xtal_mode = ext_mode == EXT_XTAL;
  wire settle_last = settle_cnt == 11'(XTAL_SETTLE_EDGES - 11'h001);

  // --------------------------------------------------------------
  // Clock multiplier
  // --------------------------------------------------------------
  // Credits smooth a x2/x4 burst into one pulse per cycle at most
  wire mult_in = mult_en && ((mult_base == MB_INT_X2) ? int_tick
                                                      : ext_tick);
  wire [3:0] mult_add = (mult_base == MB_EXT_X4) ? 4'h4 : 4'h2;
  wire       base_pulse = credits != 3'h0;
  wire [3:0] credit_sum = {1'b0, credits}
                        + (mult_in ? mult_add : 4'h0)
                        - {3'h0, base_pulse};
  wire [2:0] next_credits = credit_sum[3] ? 3'h7 : credit_sum[2:0];
  // Fractional divider: two in, one out per n, factor 2/n
  wire [2:0] scale_n = (mult_scale < SCALE_MIN) ? SCALE_MIN
                                                : mult_scale;
  wire [3:0] scale_sum = scale_acc + (base_pulse ? 4'h2 : 4'h0);
  wire       mult_tick = scale_sum >= {1'b0, scale_n};
  wire [3:0] next_scale_acc = mult_tick ? 4'(scale_sum - {1'b0, scale_n})
                                        : scale_sum;

  // --------------------------------------------------------------
  // Source switch
  // --------------------------------------------------------------
  function automatic logic src_tick(input src_t s, input logic ti,
                                    input logic te, input logic tm);
    unique case (s)
      SRC_INT:  src_tick = ti;
      SRC_EXT:  src_tick = te;
      SRC_MULT: src_tick = tm;
      default:  src_tick = 1'b0;
    endcase
  endfunction

  wire cur_tick = src_tick(cur_src, div_tick, ext_tick, mult_tick);
  wire want_switch = clk_sel != cur_src;

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------
  wire [7:0] rd_sel  = {6'h00, clk_sel};
  wire [7:0] rd_int  = {int_en, suspend, osc_run, 1'b0, div_code};
  wire [7:0] rd_ext  = {xtal_valid, ext_mode, 4'h0};
  wire [7:0] rd_mult = {mult_en, mult_en, 1'b0, mult_scale, mult_base};
  // Unmapped addresses read as zero
  wire [7:0] rd_val =
      (SFR_ADDR == ADDR_CLK_SEL) ? rd_sel
    : (SFR_ADDR == ADDR_INT_OSC) ? rd_int
    : (SFR_ADDR == ADDR_COARSE)  ? {1'b0, coarse}
    : (SFR_ADDR == ADDR_FINE)    ? {2'h0, fine}
    : (SFR_ADDR == ADDR_EXT_OSC) ? rd_ext
    : (SFR_ADDR == ADDR_MULT)    ? rd_mult
    : 8'h00;

  // --------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      clk_sel  <= SRC_INT;
      int_en   <= RST_INT_EN;
      suspend  <= 1'b0;
      div_code <= RST_DIV_CODE;
      coarse   <= RST_COARSE;
      fine     <= RST_FINE;
      ext_mode <= RST_EXT_MODE;
    end else begin
      if (wr_sel && sel_ok) begin
        clk_sel <= src_t'(wr_src);
      end
      if (wr_int) begin
        int_en   <= SFR_WDATA[INT_EN_LSB +: 2];
        div_code <= SFR_WDATA[2:0];
      end
      // Only the clock pauses; no state is lost across suspend
      suspend <= next_suspend;
      if (wr_coarse) begin
        coarse <= SFR_WDATA[6:0];
      end
      if (wr_fine) begin
        fine <= SFR_WDATA[5:0];
      end
      if (wr_ext) begin
        ext_mode <= SFR_WDATA[EXT_MODE_LSB +: 3];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      mult_en    <= 1'b0;
      mult_base  <= MB_INT_X2;
      mult_scale <= 3'h0;
    end else if (wr_mult) begin
      mult_en    <= SFR_WDATA[MULT_ENABLE_BIT];
      mult_base  <= mult_base_t'(SFR_WDATA[1:0]);
      mult_scale <= SFR_WDATA[MULT_SCALE_LSB +: 3];
    end
  end

  // --------------------------------------------------------------
  // Oscillator and divider counters
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      osc_acc <= 13'h0000;
      div_cnt <= 7'h00;
    end else if (osc_run) begin
      osc_acc <= osc_sum[12:0];
      if (int_tick) begin
        div_cnt <= 7'(div_cnt + 7'h01);
      end
    end
  end

  // --------------------------------------------------------------
  // Crystal settle detect
  // --------------------------------------------------------------
  // Any write to the control register restarts the settle count
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ext_prev   <= 1'b0;
      settle_cnt <= 11'h000;
      xtal_valid <= 1'b0;
    end else begin
      ext_prev <= EXT_OSC_IN;
      // Reconfiguring the crystal outranks a settling edge
      if (wr_ext || !xtal_mode) begin
        settle_cnt <= 11'h000;
        xtal_valid <= 1'b0;
      end else if (ext_tick && !xtal_valid) begin
        settle_cnt <= 11'(settle_cnt + 11'h001);
        xtal_valid <= settle_last;
      end
    end
  end

  // --------------------------------------------------------------
  // Multiplier state
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      credits   <= 3'h0;
      scale_acc <= 4'h0;
    end else if (!mult_en) begin
      credits   <= 3'h0;
      scale_acc <= 4'h0;
    end else begin
      credits   <= next_credits;
      scale_acc <= next_scale_acc;
    end
  end

  // --------------------------------------------------------------
  // Glitch-free changeover
  // --------------------------------------------------------------
  // Old source gives one last edge, then new source must show an
  // edge before its pulses pass; a dead source stalls the switch
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sw_state  <= SW_RUN;
      cur_src   <= SRC_INT;
      SYSTEM_CLOCK_EN <= 1'b0;
    end else begin
      unique case (sw_state)
        SW_RUN: begin
          SYSTEM_CLOCK_EN <= cur_tick;
          if (want_switch) begin
            sw_state <= SW_DRAIN;
          end
        end
        SW_DRAIN: begin
          SYSTEM_CLOCK_EN <= cur_tick;
          if (cur_tick) begin
            cur_src  <= clk_sel;
            sw_state <= SW_ARM;
          end
        end
        SW_ARM: begin
          SYSTEM_CLOCK_EN <= 1'b0;
          if (cur_tick) begin
            sw_state <= SW_RUN;
          end
        end
        default: begin
          SYSTEM_CLOCK_EN <= 1'b0;
          sw_state  <= SW_RUN;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SFR_RDATA      <= 8'h00;
      EXT_CLK_EN     <= 1'b0;
      CLK_SOURCE     <= SRC_INT;
      SYSTEM_CLOCK_STOPPED <= 1'b0;
    end else begin
      if (SFR_RE) begin
        SFR_RDATA <= rd_val;
      end
      EXT_CLK_EN     <= ext_tick;
      CLK_SOURCE     <= cur_src;
      // Stopped flag reports suspend only while internal drives the system clock
      SYSTEM_CLOCK_STOPPED <= (cur_src == SRC_INT) && suspend;
    end
  end
endmodule
`default_nettype wire

// ### tb_system_clock_selection.sv
// Self-checking bench for the system clock selection block
`default_nettype none
module tb_system_clock_selection;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_select_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] match = 4'h0;
  logic       cmp_en = 1'b0, cmp_out = 1'b1, ext_in, sys_en, ext_en;
  logic       stopped;
  src_t       src;
  int         num_errors = 0, checks_done = 0, sys_cnt = 0, ext_cnt = 0;
  int         s0, e0, want;
  // Address, write data, expected read-back
  logic [23:0] rows [13] = '{24'ha2ff7f, 24'h9eff3f, 24'ha24c4c,
    24'h9e3333, 24'ha1c7d7, 24'h979ddd, 24'h8f0300, 24'h8ffe02,
    24'h8f0101, 24'ha10707, 24'ha1c7d7, 24'h8f0000, 24'h55ff00};
  logic [15:0] dflt [6] = '{16'h8f00, 16'ha1d0, 16'ha24c, 16'h9e33,
    16'h9f00, 16'h9700};
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    sys_cnt += (sys_en === 1'b1);
    ext_cnt += (ext_en === 1'b1);
  end
  ext_osc_model #(.HALF(3)) xtal (.clk(clk), .osc(ext_in));
  system_clock_selection dut (.CLK_SYS(clk), .RST_N(rst_n),
    .SFR_ADDR(addr), .SFR_WE(we), .SFR_RE(re), .SFR_WDATA(wdata),
    .SFR_RDATA(rdata), .EXT_OSC_IN(ext_in), .PORT_MATCH(match),
    .CMP0_ENABLE(cmp_en), .CMP0_OUT(cmp_out), .SYSTEM_CLOCK_EN(sys_en),
    .EXT_CLK_EN(ext_en), .CLK_SOURCE(src), .SYSTEM_CLOCK_STOPPED(stopped));
  // ----------------------------------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------------------------------
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    tick();
    we = 1'b0;
    tick();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    addr = a;
    re = 1'b1;
    tick();
    re = 1'b0;
    check("read data", rdata, e);
    tick();
  endtask
  task automatic wrap_up();
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #(25ns * 100000);
    num_errors++;
    wrap_up();
  end
  initial begin
    tick(10);
    rst_n = 1'b1;
    tick();
    wr(ADDR_EXT_OSC, 8'h60);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
      for (int k = 0; k < 300 && src !== rows[i][1:0]; k++)
        tick();
      if (rows[i][23:16] == ADDR_CLK_SEL)
        check("source", 8'(src), rows[i][7:0]);
    end
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_INT_OSC, 8'hc0 | 8'(c));
      tick(260);
      s0 = sys_cnt;
      want = 768 >> (7 - c);
      tick(1280);
      check("int rate", 8'(sys_cnt - s0 >= want - 2 &&
        sys_cnt - s0 <= want + 2), 8'h01);
    end
    cmp_en = 1'b1;
    for (int w = 0; w < 5; w++) begin
      wr(ADDR_INT_OSC, 8'he7);
      tick(4);
      check("stopped", 8'(stopped), 8'h01);
      s0 = sys_cnt;
      e0 = ext_cnt;
      tick(24);
      check("halted pulses", 8'(sys_cnt - s0), 8'h00);
      check("ext pulses", 8'(ext_cnt - e0), 8'h04);
      if (w < 4)
        match[w] = 1'b1;
      else
        cmp_out = 1'b0;
      tick();
      match = 4'h0;
      cmp_out = 1'b1;
      tick(4);
      check("woken", 8'(stopped), 8'h00);
      rd(ADDR_INT_OSC, 8'hd7);
    end
    wr(ADDR_MULT, 8'h8a);
    wr(ADDR_CLK_SEL, 8'h02);
    for (int k = 0; k < 300 && src !== SRC_MULT; k++)
      tick();
    check("mult source", 8'(src), 8'h02);
    tick(50);
    s0 = sys_cnt;
    tick(1200);
    // One external edge per 6 cycles, x4, factor 1
    want = 800;
    e0 = sys_cnt - s0 - want;
    check("ext x4 rate", 8'(e0 >= -2 && e0 <= 2), 8'h01);
    wr(ADDR_COARSE, 8'h20);
    wr(ADDR_MULT, 8'h90);
    rd(ADDR_MULT, 8'hd0);
    tick(50);
    s0 = sys_cnt;
    tick(1200);
    // Trims 20/33 give a step of 2099; x2 then factor 2/4
    want = 1200 * 2099 / 8192;
    e0 = sys_cnt - s0 - want;
    check("int x2 rate", 8'(e0 >= -3 && e0 <= 3), 8'h01);
    tick(30000);
    rd(ADDR_EXT_OSC, 8'he0);
    wr(ADDR_EXT_OSC, 8'h10);
    rd(ADDR_EXT_OSC, 8'h10);
    rst_n = 1'b0;
    tick(10);
    rst_n = 1'b1;
    tick();
    check("boot source", 8'(src), 8'h00);
    foreach (dflt[i])
      rd(dflt[i][15:8], dflt[i][7:0]);
    wrap_up();
  end
endmodule
`default_nettype wire
